// ===== hdl/hbd_debounce.sv
// glitch suppression: output follows input after N stable sampling ticks
`timescale 1ns/1ps
`default_nettype none

module hbd_debounce #(
  parameter int unsigned SAMPLES = hbd_pkg::DEBOUNCE_SAMPLES
) (
  input  wire logic i_clk_sys,
  input  wire logic i_rst_n,
  input  wire logic i_en,
  input  wire logic i_bypass,
  input  wire logic i_tick,
  input  wire logic i_raw,
  output logic      o_state
);

  localparam int unsigned CNT_W = $clog2(SAMPLES) + 1;

  typedef struct packed {
    logic             stable;
    logic [CNT_W-1:0] cnt;
  } deb_state_t;

  deb_state_t st_q;
  deb_state_t st_d;

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    st_d = st_q;
    if (!i_en) begin
      st_d.stable = 1'b0;
      st_d.cnt    = '0;
    end else if (i_bypass) begin
      st_d.stable = i_raw;
      st_d.cnt    = '0;
    end else if (i_raw == st_q.stable) begin
      // any bounce back restarts the whole interval
      st_d.cnt = '0;
    end else if (i_tick) begin
      if (st_q.cnt == CNT_W'(SAMPLES - 1)) begin
        st_d.stable = i_raw;
        st_d.cnt    = '0;
      end else begin
        st_d.cnt = st_q.cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_state = st_q.stable;

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  sequence s_last_sample;
    i_en && !i_bypass && i_tick && (i_raw != st_q.stable) && (st_q.cnt == CNT_W'(SAMPLES - 1));
  endsequence

  AST_DEB_ACCEPT: assert property (s_last_sample |=> o_state == $past(i_raw))
    else $error("debounced state did not take the held input");

  AST_DEB_ONLY_AFTER_INTERVAL: assert property (
    ($changed(o_state) && $past(i_en) && !$past(i_bypass)) |-> $past(st_q.cnt) == CNT_W'(SAMPLES - 1) && $past(i_tick))
    else $error("debounced state changed before the full interval");

endmodule

`default_nettype wire

// ===== hdl/hbd_pkg.sv
// shared constants for the headset and button detection block
`default_nettype none

package hbd_pkg;

  // ==========================================================================
  // timing
  // ==========================================================================
  localparam int unsigned CLK_HZ               = 20_000_000;
  localparam int unsigned BASE_TICK_US         = 1000;
  localparam int unsigned BASE_TICK_CYCLES     = BASE_TICK_US * (CLK_HZ / 1_000_000);
  localparam int unsigned TICK_W               = 7;
  localparam int unsigned JACK_DEBOUNCE_MS_MIN = 16;
  localparam int unsigned JACK_TICK_MS_MIN     = 2;
  localparam int unsigned BTN_DEBOUNCE_MS_MIN  = 8;
  localparam int unsigned BTN_TICK_MS_MIN      = 1;
  localparam int unsigned DEBOUNCE_SAMPLES     = JACK_DEBOUNCE_MS_MIN / JACK_TICK_MS_MIN;

  // ==========================================================================
  // register map
  // ==========================================================================
  localparam int unsigned ADDR_W        = 7;
  localparam logic [6:0]  REG_DETECT_A  = 7'h0D;
  localparam logic [6:0]  REG_DETECT_B  = 7'h0E;
  localparam logic [7:0]  RESET_A       = 8'h00;
  localparam logic [7:0]  RESET_B       = 8'h00;
  localparam logic [7:0]  RDATA_UNMAPPED = 8'h00;

  localparam int unsigned A_DET_EN_BIT  = 7;
  localparam int unsigned A_TYPE_LSB    = 5;
  localparam int unsigned A_JACK_DB_LSB = 2;
  localparam int unsigned A_BTN_DB_LSB  = 0;
  localparam int unsigned B_AC_BIT      = 7;
  localparam int unsigned B_FDIFF_BIT   = 6;
  localparam int unsigned B_PRESS_BIT   = 5;
  localparam int unsigned B_PRESENT_BIT = 4;
  localparam int unsigned B_PDIFF_BIT   = 3;

  localparam logic [2:0]  JACK_DB_MAX_CODE = 3'h5;
  localparam logic [2:0]  JACK_TICK_SLOWEST = 3'h6;
  localparam logic [1:0]  BTN_DB_OFF       = 2'h0;
  localparam logic [2:0]  RSVD_B_VALUE     = 3'h0;

  typedef enum logic [1:0] {
    HS_NONE   = 2'h0,
    HS_STEREO = 2'h1,
    HS_CELL   = 2'h2,
    HS_BOTH   = 2'h3
  } headset_type_t;

endpackage

`default_nettype wire

// ===== hdl/hbd_tick_gen.sv
// millisecond sampling tick generator, 1 ms to 64 ms in powers of two
`timescale 1ns/1ps
`default_nettype none

module hbd_tick_gen #(
  parameter int unsigned BASE_CYCLES = hbd_pkg::BASE_TICK_CYCLES
) (
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_rst_n,
  input  wire logic                      i_en,
  output logic [hbd_pkg::TICK_W-1:0]     o_tick
);

  localparam int unsigned CW = (BASE_CYCLES > 2) ? $clog2(BASE_CYCLES) : 1;

  typedef struct packed {
    logic [CW-1:0]               base_cnt;
    logic [5:0]                  ms_cnt;
    logic [hbd_pkg::TICK_W-1:0]  tick;
  } tick_state_t;

  tick_state_t st_q;
  tick_state_t st_d;

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    st_d      = st_q;
    st_d.tick = '0;
    if (!i_en) begin
      // restart so the first tick after enable is a full period away
      st_d.base_cnt = '0;
      st_d.ms_cnt   = '0;
    end else if (st_q.base_cnt == CW'(BASE_CYCLES - 1)) begin
      st_d.base_cnt = '0;
      st_d.ms_cnt   = st_q.ms_cnt + 6'h01;
      st_d.tick[0]  = 1'b1;
      for (int i = 1; i < hbd_pkg::TICK_W; i++) begin
        st_d.tick[i] = ((st_q.ms_cnt & 6'((7'h01 << i) - 7'h01)) == 6'((7'h01 << i) - 7'h01));
      end
    end else begin
      st_d.base_cnt = st_q.base_cnt + CW'(1);
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_tick = st_q.tick;

endmodule

`default_nettype wire

// ===== hdl/hbd_top.sv
// headset jack and button press detection with its register pair
// ============================================================================
// ============================================================================
`timescale 1ns/1ps
`default_nettype none

module hbd_top #(
  parameter int unsigned BASE_TICK_CYCLES = hbd_pkg::BASE_TICK_CYCLES
) (
  input  wire logic                        i_clk_sys,
  input  wire logic                        i_rst_n,
  input  wire logic [hbd_pkg::ADDR_W-1:0]  i_reg_addr,
  input  wire logic                        i_reg_wr,
  input  wire logic                        i_reg_rd,
  input  wire logic [7:0]                  i_reg_wdata,
  input  wire logic                        i_jack_stereo,
  input  wire logic                        i_jack_cell,
  input  wire logic                        i_button,
  output logic [7:0]                       o_reg_rdata,
  output logic [1:0]                       o_headset_type,
  output logic                             o_headset_present,
  output logic                             o_button_flag,
  output logic                             o_drv_ac_coupled,
  output logic                             o_drv_fully_diff,
  output logic                             o_drv_pseudo_diff
);

  // ==========================================================================
  // reset release
  // ==========================================================================
  logic [1:0] rst_sync_q;
  logic       rst_n_q;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n_q = rst_sync_q[1];

  // ==========================================================================
  // state
  // ==========================================================================
  // bit 0 stereo comparator, 1 cellular comparator, 2 button
  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic [2:0] filt;
    logic       det_en;
    logic [2:0] jack_db;
    logic [1:0] btn_db;
    logic       ac_coupled;
    logic       fully_diff;
    logic       pseudo_diff;
    logic       press_flag;
    logic       btn_prev;
    logic       present;
    logic [7:0] rdata;
  } top_state_t;

  top_state_t st_q;
  top_state_t st_d;

  logic [hbd_pkg::TICK_W-1:0] tick;
  logic                       stereo_db;
  logic                       cell_db;
  logic                       button_db;
  logic                       jack_tick;
  logic                       btn_tick;
  logic                       press_evt;
  logic                       rd_a;
  logic                       rd_b;
  logic                       wr_a;
  logic                       wr_b;
  logic [1:0]                 hs_type;

  // ==========================================================================
  // tick selection
  // ==========================================================================
  // reserved jack codes fall back to the slowest rate rather than a fast one
  function automatic logic [2:0] jack_tick_idx(input logic [2:0] code);
    if (code > hbd_pkg::JACK_DB_MAX_CODE) begin
      return hbd_pkg::JACK_TICK_SLOWEST;
    end
    return code + 3'h1;
  endfunction

  function automatic logic [2:0] btn_tick_idx(input logic [1:0] code);
    if (code == hbd_pkg::BTN_DB_OFF) begin
      return 3'h0;
    end
    return {1'b0, code} - 3'h1;
  endfunction

  assign jack_tick = tick[jack_tick_idx(st_q.jack_db)];
  assign btn_tick  = tick[btn_tick_idx(st_q.btn_db)];

  // ==========================================================================
  // sampling and debounce
  // ==========================================================================
  hbd_tick_gen #(
    .BASE_CYCLES (BASE_TICK_CYCLES)
  ) u_tick (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n_q),
    .i_en      (st_q.det_en),
    .o_tick    (tick)
  );

  hbd_debounce #(
    .SAMPLES (hbd_pkg::DEBOUNCE_SAMPLES)
  ) u_deb_stereo (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n_q),
    .i_en      (st_q.det_en),
    .i_bypass  (1'b0),
    .i_tick    (jack_tick),
    .i_raw     (st_q.filt[0]),
    .o_state   (stereo_db)
  );

  hbd_debounce #(
    .SAMPLES (hbd_pkg::DEBOUNCE_SAMPLES)
  ) u_deb_cell (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n_q),
    .i_en      (st_q.det_en),
    .i_bypass  (1'b0),
    .i_tick    (jack_tick),
    .i_raw     (st_q.filt[1]),
    .o_state   (cell_db)
  );

  hbd_debounce #(
    .SAMPLES (hbd_pkg::BTN_DEBOUNCE_MS_MIN / hbd_pkg::BTN_TICK_MS_MIN)
  ) u_deb_button (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n_q),
    .i_en      (st_q.det_en),
    .i_bypass  (st_q.btn_db == hbd_pkg::BTN_DB_OFF),
    .i_tick    (btn_tick),
    .i_raw     (st_q.filt[2]),
    .o_state   (button_db)
  );

  // debouncers are cleared while detection is off, so type reads none
  assign hs_type   = {cell_db, stereo_db};
  assign press_evt = st_q.det_en && button_db && !st_q.btn_prev;

  // ==========================================================================
  // register access decode
  // ==========================================================================
  assign rd_a = i_reg_rd && (i_reg_addr == hbd_pkg::REG_DETECT_A);
  assign rd_b = i_reg_rd && (i_reg_addr == hbd_pkg::REG_DETECT_B);
  assign wr_a = i_reg_wr && (i_reg_addr == hbd_pkg::REG_DETECT_A);
  assign wr_b = i_reg_wr && (i_reg_addr == hbd_pkg::REG_DETECT_B);

  // ==========================================================================
  // next state
  // ==========================================================================
  always_comb begin
    st_d = st_q;

    st_d.sync1 = {i_button, i_jack_cell, i_jack_stereo};
    st_d.sync2 = st_q.sync1;
    st_d.sync3 = st_q.sync2;
    for (int i = 0; i < 3; i++) begin
      if (st_q.sync2[i] == st_q.sync3[i]) begin
        st_d.filt[i] = st_q.sync3[i];
      end
    end

    st_d.btn_prev = button_db;
    st_d.present  = |hs_type;

    if (wr_a) begin
      st_d.det_en  = i_reg_wdata[hbd_pkg::A_DET_EN_BIT];
      st_d.jack_db = i_reg_wdata[hbd_pkg::A_JACK_DB_LSB +: 3];
      st_d.btn_db  = i_reg_wdata[hbd_pkg::A_BTN_DB_LSB +: 2];
    end
    if (wr_b) begin
      st_d.ac_coupled  = i_reg_wdata[hbd_pkg::B_AC_BIT];
      st_d.fully_diff  = i_reg_wdata[hbd_pkg::B_FDIFF_BIT];
      st_d.pseudo_diff = i_reg_wdata[hbd_pkg::B_PDIFF_BIT];
    end

    // a press landing in the clearing read survives to the next read
    if (press_evt) begin
      st_d.press_flag = 1'b1;
    end else if (rd_b) begin
      st_d.press_flag = 1'b0;
    end

    if (rd_a) begin
      st_d.rdata = '0;
      st_d.rdata[hbd_pkg::A_DET_EN_BIT]       = st_q.det_en;
      st_d.rdata[hbd_pkg::A_TYPE_LSB +: 2]    = hs_type;
      st_d.rdata[hbd_pkg::A_JACK_DB_LSB +: 3] = st_q.jack_db;
      st_d.rdata[hbd_pkg::A_BTN_DB_LSB +: 2]  = st_q.btn_db;
    end else if (rd_b) begin
      st_d.rdata = '0;
      st_d.rdata[hbd_pkg::B_AC_BIT]      = st_q.ac_coupled;
      st_d.rdata[hbd_pkg::B_FDIFF_BIT]   = st_q.fully_diff;
      st_d.rdata[hbd_pkg::B_PRESS_BIT]   = st_q.press_flag;
      st_d.rdata[hbd_pkg::B_PRESENT_BIT] = st_q.present;
      st_d.rdata[hbd_pkg::B_PDIFF_BIT]   = st_q.pseudo_diff;
    end else if (i_reg_rd) begin
      st_d.rdata = hbd_pkg::RDATA_UNMAPPED;
    end
  end

  always_ff @(posedge i_clk_sys or negedge rst_n_q) begin
    if (!rst_n_q) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // outputs
  // ==========================================================================
  assign o_reg_rdata       = st_q.rdata;
  assign o_headset_type    = hs_type;
  assign o_headset_present = st_q.present;
  assign o_button_flag     = st_q.press_flag;
  assign o_drv_ac_coupled  = st_q.ac_coupled;
  assign o_drv_fully_diff  = st_q.fully_diff;
  assign o_drv_pseudo_diff = st_q.pseudo_diff;

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!rst_n_q);

  sequence s_read_b;
    rd_b && !press_evt;
  endsequence

  AST_DET_OFF_NONE: assert property (!st_q.det_en |=> o_headset_type == 2'h0)
    else $error("headset type reported while detection disabled");

  AST_TYPE_READBACK: assert property (rd_a |=> o_reg_rdata[6:5] == $past(o_headset_type))
    else $error("type field does not show detected headset");

  AST_BTN_BYPASS: assert property (
    (st_q.det_en && st_q.btn_db == 2'h0) |=> button_db == $past(st_q.filt[2]))
    else $error("button not passed through with debounce off");

  AST_PRESS_SET: assert property (press_evt |=> o_button_flag)
    else $error("press flag not set by a debounced press");

  AST_PRESS_CLEAR: assert property (s_read_b |=> !o_button_flag && o_reg_rdata[5] == $past(o_button_flag))
    else $error("press flag not returned and cleared by read");

  AST_PRESENT: assert property (o_headset_present == $past(|o_headset_type))
    else $error("present flag disagrees with headset type");

  AST_AC_COUPLED: assert property (wr_b |=> o_drv_ac_coupled == $past(i_reg_wdata[7]))
    else $error("coupling bit not written");

  AST_FULLY_DIFF: assert property (wr_b |=> o_drv_fully_diff == $past(i_reg_wdata[6]))
    else $error("fully differential bit not written");

  AST_PSEUDO_DIFF: assert property (wr_b |=> o_drv_pseudo_diff == $past(i_reg_wdata[3]))
    else $error("pseudo differential bit not written");

  AST_RSVD_ZERO: assert property (rd_b |=> o_reg_rdata[2:0] == 3'h0)
    else $error("reserved bits read nonzero");

  AST_JACK_HOLD: assert property (
    (st_q.det_en && $changed(st_q.jack_db) == 1'b0 && !jack_tick) |=> $stable(o_headset_type))
    else $error("jack state moved without a sampling tick");

  // the flag only drops through a read of the status register
  AST_PRESS_HOLD: assert property ((o_button_flag && !rd_b) |=> o_button_flag)
    else $error("press flag dropped without a read");

  AST_NO_PRESS_OFF: assert property ((!st_q.det_en && !o_button_flag) |=> !o_button_flag)
    else $error("press flag set while detection disabled");

  AST_DRV_HOLD: assert property (!wr_b |=> $stable({o_drv_ac_coupled, o_drv_fully_diff, o_drv_pseudo_diff}))
    else $error("driver configuration moved without a write");

  sequence s_press_then_read;
    press_evt ##1 (o_button_flag && rd_b && !press_evt);
  endsequence

  AST_PRESS_REPORTED: assert property (s_press_then_read |=> o_reg_rdata[5] && !o_button_flag)
    else $error("detected press not reported by the next read");

endmodule

`default_nettype wire

// ===== tb/hbd_frontend_model.sv
// comparator front end model for the jack and button lines
`timescale 1ns/1ps
`default_nettype none

module hbd_frontend_model (
  input  wire logic       i_clk_sys,
  input  wire logic [2:0] i_level,
  output logic            o_jack_stereo,
  output logic            o_jack_cell,
  output logic            o_button
);
  logic [2:0] seen  = 3'h0;
  logic [2:0] chg   = 3'h0;
  logic [2:0] lines = 3'h0;
  int         bounce = 0;

  // ==========================================================================
  // contact chatter
  // ==========================================================================
  // a changed line toggles each cycle before settling, far faster than any
  // sampling tick; moves 2 ns after the edge so the bench's 1 ns drive lands first
  always @(posedge i_clk_sys) begin
    #2;
    if (i_level !== seen) begin
      chg = i_level ^ seen;
      seen = i_level;
      bounce = 4;
    end
    if (bounce != 0) begin
      bounce--;
      lines = bounce[0] ? (seen ^ chg) : seen;
    end else begin
      lines = seen;
    end
  end

  assign o_jack_stereo = lines[0];
  assign o_jack_cell   = lines[1];
  assign o_button      = lines[2];
endmodule

`default_nettype wire

// ===== tb/headset_button_detect_test.sv
// self-checking bench for the headset and button detection block
`timescale 1ns/1ps
`default_nettype none

module headset_button_detect_test;
  // ==========================================================================
  // clock, reset and instances
  // ==========================================================================
  localparam int unsigned BASE = 4;
  localparam time         DLY  = 1ns;
  logic       i_clk_sys   = 1'b0;
  logic       i_rst_n     = 1'b0;
  logic [6:0] i_reg_addr  = 7'h00;
  logic       i_reg_wr    = 1'b0;
  logic       i_reg_rd    = 1'b0;
  logic [7:0] i_reg_wdata = 8'h00;
  logic [2:0] fe_level    = 3'h0;
  logic       jack_stereo;
  logic       jack_cell;
  logic       button;
  logic [7:0] o_reg_rdata;
  logic [1:0] o_headset_type;
  logic       o_headset_present;
  logic       o_button_flag;
  logic       o_drv_ac_coupled;
  logic       o_drv_fully_diff;
  logic       o_drv_pseudo_diff;
  int         n_errors    = 0;
  int         check_count = 0;

  always #25 i_clk_sys = ~i_clk_sys;

  hbd_frontend_model hbd_frontend_model_i (
    .i_clk_sys(i_clk_sys), .i_level(fe_level),
    .o_jack_stereo(jack_stereo), .o_jack_cell(jack_cell), .o_button(button)
  );

  hbd_top #(.BASE_TICK_CYCLES(BASE)) hbd_top_i (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
    .i_jack_stereo(jack_stereo), .i_jack_cell(jack_cell), .i_button(button),
    .o_reg_rdata(o_reg_rdata), .o_headset_type(o_headset_type),
    .o_headset_present(o_headset_present), .o_button_flag(o_button_flag),
    .o_drv_ac_coupled(o_drv_ac_coupled), .o_drv_fully_diff(o_drv_fully_diff),
    .o_drv_pseudo_diff(o_drv_pseudo_diff)
  );

  // ==========================================================================
  // tasks
  // ==========================================================================
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_rng(input string what, input int lo, input int hi, input int got);
    check_count++;
    if (got < lo || got > hi) begin
      n_errors++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask

  task automatic reg_wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge i_clk_sys) #DLY;
    i_reg_addr = a;
    i_reg_wdata = d;
    i_reg_wr = 1'b1;
    @(posedge i_clk_sys) #DLY;
    i_reg_wr = 1'b0;
  endtask

  // read data is taken one edge after the strobe edge; it stands until the next read
  task automatic rd_chk(input string what, input logic [6:0] a, input logic [7:0] exp);
    @(posedge i_clk_sys) #DLY;
    i_reg_addr = a;
    i_reg_rd = 1'b1;
    @(posedge i_clk_sys) #DLY;
    i_reg_rd = 1'b0;
    @(posedge i_clk_sys) #DLY;
    chk(what, exp, o_reg_rdata);
  endtask

  // counts cycles until the flag rises or the type reaches t, at most lim
  task automatic wait_out(input bit flag, input logic [1:0] t, input int lim, output int n);
    n = 0;
    while (n < lim && (flag ? o_button_flag !== 1'b1 : o_headset_type !== t)) begin
      @(posedge i_clk_sys) #DLY;
      n++;
    end
  endtask

  task automatic close_out;
    $display("counts: checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #(60000 * 50ns);
    n_errors++;
    $display("MISMATCH watchdog expected done seen hang");
    close_out();
  end

  // ==========================================================================
  // tests
  // ==========================================================================
  initial begin
    int n;
    int tick;
    logic [1:0] ty;
    repeat (16) @(posedge i_clk_sys);
    #DLY i_rst_n = 1'b1;
    repeat (3) @(posedge i_clk_sys);
    rd_chk("control reset", 7'h0D, 8'h00);
    rd_chk("status reset", 7'h0E, 8'h00);
    reg_wr(7'h0F, 8'hFF);
    rd_chk("unmapped read", 7'h0F, 8'h00);
    reg_wr(7'h0E, 8'hB8);
    rd_chk("status read only bits", 7'h0E, 8'h88);
    chk("drive bits ac pseudo", 8'h05, {5'h00, o_drv_ac_coupled, o_drv_fully_diff, o_drv_pseudo_diff});
    reg_wr(7'h0E, 8'h40);
    rd_chk("fully diff readback", 7'h0E, 8'h40);
    chk("drive bits fully", 8'h02, {5'h00, o_drv_ac_coupled, o_drv_fully_diff, o_drv_pseudo_diff});
    $display("test registers done");

    fe_level = 3'h7;
    repeat (300) @(posedge i_clk_sys);
    #DLY;
    chk("type while disabled", 8'h00, {6'h00, o_headset_type});
    chk("flag while disabled", 8'h00, {7'h00, o_button_flag});
    fe_level = 3'h0;
    repeat (20) @(posedge i_clk_sys);
    #DLY;
    $display("test disabled done");

    // only codes 000..101 are ever written
    for (int c = 0; c < 6; c++) begin
      tick = BASE << (c + 1);
      ty = 2'(c % 3 + 1);
      reg_wr(7'h0D, {1'b1, 2'h0, 3'(c), 2'h0});
      fe_level = {1'b0, ty};
      wait_out(1'b0, ty, 8 * tick + 17, n);
      chk_rng("jack debounce cycles", 7 * tick, 8 * tick + 16, n);
      rd_chk("type field", 7'h0D, {1'b1, ty, 3'(c), 2'h0});
      rd_chk("present flag", 7'h0E, 8'h50);
      chk("present output", 8'h01, {7'h00, o_headset_present});
      fe_level = 3'h0;
      wait_out(1'b0, 2'h0, 8 * tick + 17, n);
      chk_rng("jack release cycles", 7 * tick, 8 * tick + 16, n);
      rd_chk("present cleared", 7'h0E, 8'h40);
      chk("present output cleared", 8'h00, {7'h00, o_headset_present});
    end
    $display("test jack codes done");

    // a low gap inside the interval must restart the count
    reg_wr(7'h0D, 8'h80);
    fe_level = 3'h1;
    repeat (40) @(posedge i_clk_sys);
    #DLY fe_level = 3'h0;
    repeat (16) @(posedge i_clk_sys);
    #DLY fe_level = 3'h1;
    wait_out(1'b0, 2'h1, 81, n);
    chk_rng("restart after glitch", 56, 80, n);
    fe_level = 3'h0;
    wait_out(1'b0, 2'h0, 81, n);
    chk_rng("release after glitch", 56, 80, n);
    $display("test glitch done");

    for (int b = 0; b < 4; b++) begin
      tick = (b == 0) ? 0 : BASE << (b - 1);
      reg_wr(7'h0D, {1'b1, 5'h00, 2'(b)});
      fe_level = 3'h4;
      wait_out(1'b1, 2'h0, 8 * tick + 17, n);
      chk_rng("button debounce cycles", 7 * tick, 8 * tick + 16, n);
      rd_chk("press flag set", 7'h0E, 8'h60);
      rd_chk("press flag cleared", 7'h0E, 8'h40);
      fe_level = 3'h0;
      repeat (8 * tick + 20) @(posedge i_clk_sys);
      #DLY;
      rd_chk("no flag on release", 7'h0E, 8'h40);
    end
    $display("test button codes done");
    close_out();
  end
endmodule

`default_nettype wire
